// ---- verilog/lsb_pkg.sv ----
// Purpose: Shared constants and packet carriers for the local to system bus converter
// Assumes: One local bus clock; packets move in single-cycle beats
// Notes:   Packet opcodes and reply kinds are internal encodings of this block
package lsb_pkg;

    // Request opcodes on the system bus
    localparam logic [2:0] OP_READ_BYTE    = 3'h0;
    localparam logic [2:0] OP_READ_DBYTE   = 3'h1;
    localparam logic [2:0] OP_READ_WORD    = 3'h2;
    localparam logic [2:0] OP_LOCKED_READ  = 3'h3;
    localparam logic [2:0] OP_WRITE_WORD   = 3'h4;
    localparam logic [2:0] OP_LOCKED_WRITE = 3'h5;
    localparam logic [2:0] OP_INTERAGENT   = 3'h6;

    // Reply kinds carried in the first beat of a reply
    localparam logic [1:0] RPL_DATA = 2'h0;
    localparam logic [1:0] RPL_WACK = 2'h1;
    localparam logic [1:0] RPL_NACK = 2'h2;
    localparam logic [1:0] RPL_BAD  = 2'h3;

    // Lane patterns
    localparam logic [3:0] LANES_ALL   = 4'hf;
    localparam logic [3:0] LANES_LOWER = 4'h3;
    localparam logic [3:0] LANES_UPPER = 4'hc;
    localparam logic [3:0] LANES_NONE  = 4'h0;

    // Reset values and counts
    localparam logic [1:0]  LOW_ADDR_ZERO   = 2'h0;
    localparam logic [31:0] WORD_ZERO       = 32'h0000_0000;
    localparam logic [3:0]  OUTSTANDING_MAX = 4'hf;
    localparam logic [3:0]  OUTSTANDING_ONE = 4'h1;
    localparam logic [3:0]  COUNT_ZERO      = 4'h0;
    localparam logic [11:0] RPL_TIMEOUT_CYC = 12'h400;
    localparam logic [11:0] TIMER_ZERO      = 12'h000;

    // Outgoing and incoming request packet
    typedef struct packed {
        logic [2:0]  op;
        logic [31:0] addr;
        logic [31:0] data;
        logic [3:0]  marks;
    } lsb_req_s;

    // Reply packet beat
    typedef struct packed {
        logic [1:0]  kind;
        logic        forWrite;
        logic        last;
        logic [31:0] addr;
        logic [31:0] data;
    } lsb_rpl_s;

    // Requesting-side sequencer
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_RECOG = 3'b001,
        ST_SEND  = 3'b011,
        ST_WAIT  = 3'b010,
        ST_DONE  = 3'b110,
        ST_DRAIN = 3'b111
    } lsb_state_e;

endpackage : lsb_pkg

// ---- verilog/lsb_bridge.sv ----
// Purpose: Local bus to system bus request converter, both requesting and serving halves
// Assumes: Processor logic runs on clk_sys; one word per local transaction
// Notes:   Replies arrive in order; one failed-write address is remembered
// Summary of operation
// - One enabled read lane: byte read packet
// - Halfword lane pair read: double-byte packet
// - Other reads: word packet, low bits zero
// - Served byte/halfword reads decode lane enables
// - Served word reads enable all lanes
// - Lock falling on a read: locked read
// - Accesses inside lock pass as ordinary
// - Lock rising on a write: drain, locked write
// - Unclaimed addresses ignore the lock line
// - Serving side acks or nacks each message
// - Nack shows bad access at data end
// - Messages wait until their reply arrives
// - Timeout gives bad access for reads, messages
// - Failed write flags the later read instead
// - Bad kind first beat; flag last cycle
// - Writes go as words with byte marks
// - One recognition wait; reads wait for data
// - Locked read data after whole reply
// - Sequenced writes wait for write reply
// - Incoming message waits until reply sent
// - Cacheable: claimed, hint high, not locked
`timescale 1ns/10ps
module lsb_bridge (
    input  wire logic            clk_sys,
    input  wire logic            rst_n,
    input  wire logic            addrCycle,
    input  wire logic [31:0]     lclAddr,
    input  wire logic            lclWrite,
    input  wire logic [3:0]      byteLaneEnable,
    input  wire logic            busLockN,
    input  wire logic            cacheHint,
    input  wire logic            recogHit,
    input  wire logic            seqFlag,
    input  wire logic            interagentMessage,
    input  wire logic [31:0]     lclWdata,
    output logic                 readyN,
    output logic                 badAccessN,
    output logic [31:0]          lclRdata,
    output logic                 cacheable,
    output logic                 reqValid,
    input  wire logic            reqReady,
    output lsb_pkg::lsb_req_s    reqPkt,
    input  wire logic            rplValid,
    input  wire lsb_pkg::lsb_rpl_s rplPkt,
    input  wire logic            inReqValid,
    output logic                 inReqReady,
    input  wire lsb_pkg::lsb_req_s inReqPkt,
    input  wire logic            msgBufFull,
    input  wire logic            msgPrioOk,
    input  wire logic            msgIsReg,
    input  wire logic            msgRegOk,
    output logic                 srvValid,
    output logic [3:0]           srvLanes,
    output logic [3:0]           srvStrobes,
    output logic                 srvWaitN,
    output logic                 srvRplValid,
    input  wire logic            srvRplReady,
    output lsb_pkg::lsb_rpl_s    srvRplPkt
);

    // Low address bits from one lane or a halfword pair
    function automatic logic [1:0] lowBitsFromLanes(input logic [3:0] lanes);
        logic [1:0] bits;
        bits = lsb_pkg::LOW_ADDR_ZERO;
        unique case (lanes)
            4'h2:    bits = 2'h1;
            4'h4:    bits = 2'h2;
            4'h8:    bits = 2'h3;
            4'hc:    bits = 2'h2;
            default: bits = lsb_pkg::LOW_ADDR_ZERO;
        endcase
        return bits;
    endfunction : lowBitsFromLanes

    // Lane enables for a served read packet
    function automatic logic [3:0] lanesFromOp(input logic [2:0] op, input logic [1:0] low);
        logic [3:0] lanes;
        lanes = lsb_pkg::LANES_ALL;
        if (op == lsb_pkg::OP_READ_BYTE) begin
            lanes = 4'h1 << low;
        end else if (op == lsb_pkg::OP_READ_DBYTE) begin
            lanes = low[1] ? lsb_pkg::LANES_UPPER : lsb_pkg::LANES_LOWER;
        end
        return lanes;
    endfunction : lanesFromOp

    lsb_pkg::lsb_state_e state_reg;
    lsb_pkg::lsb_state_e state_next;
    lsb_pkg::lsb_req_s   reqPkt_reg;
    logic                lockPrevN_reg;
    logic                curPosted_reg;
    logic                curLockedRd_reg;
    logic                curLockedWr_reg;
    logic                curRead_reg;
    logic                curMsg_reg;
    logic                firstBeat_reg;
    logic                badFlag_reg;
    logic [3:0]          outstanding_reg;
    logic [11:0]         timer_reg;
    logic                failValid_reg;
    logic [31:0]         failAddr_reg;
    logic [31:0]         lclRdata_reg;
    logic                cacheable_reg;
    logic                srvPending_reg;
    lsb_pkg::lsb_rpl_s   srvRplPkt_reg;
    logic                srvValid_reg;
    logic [3:0]          srvLanes_reg;
    logic [3:0]          srvStrobes_reg;
    logic                takeReq;
    logic                lockedRd;
    logic                lockedWr;
    logic                oneLane;
    logic                pairLane;
    logic                sendDone;
    logic                wrRplOk;
    logic                rplMine;
    logic                rplFinish;
    logic                timeout;
    logic                waitDone;
    logic                readyPulse;
    logic                wrSent;
    logic                wrFailed;

    // Only claimed addresses look at the lock line
    assign takeReq  = addrCycle && recogHit && (state_reg == lsb_pkg::ST_IDLE);
    assign lockedRd = !lclWrite && lockPrevN_reg && !busLockN;
    assign lockedWr = lclWrite && !lockPrevN_reg && busLockN;
    assign oneLane  = $onehot(byteLaneEnable);
    assign pairLane = (byteLaneEnable == lsb_pkg::LANES_LOWER) ||
                      (byteLaneEnable == lsb_pkg::LANES_UPPER);

    // Lock history follows claimed address cycles only
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lockPrevN_reg <= 1'b1;
        end else if (takeReq) begin
            lockPrevN_reg <= busLockN;
        end
    end

    // Packet formed in the address cycle; held until the system bus takes it
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reqPkt_reg <= '0;
        end else if (takeReq) begin
            reqPkt_reg.addr  <= {lclAddr[31:2], lsb_pkg::LOW_ADDR_ZERO};
            reqPkt_reg.data  <= lclWdata;
            reqPkt_reg.marks <= lclWrite ? byteLaneEnable : lsb_pkg::LANES_NONE;
            if (interagentMessage) begin
                reqPkt_reg.op <= lsb_pkg::OP_INTERAGENT;
            end else if (lclWrite) begin
                // Inside a held lock writes stay ordinary
                reqPkt_reg.op <= lockedWr ? lsb_pkg::OP_LOCKED_WRITE : lsb_pkg::OP_WRITE_WORD;
            end else if (lockedRd) begin
                reqPkt_reg.op <= lsb_pkg::OP_LOCKED_READ;
            end else if (oneLane) begin
                reqPkt_reg.op      <= lsb_pkg::OP_READ_BYTE;
                reqPkt_reg.addr[1:0] <= lowBitsFromLanes(byteLaneEnable);
            end else if (pairLane) begin
                reqPkt_reg.op      <= lsb_pkg::OP_READ_DBYTE;
                reqPkt_reg.addr[1:0] <= lowBitsFromLanes(byteLaneEnable);
            end else begin
                reqPkt_reg.op <= lsb_pkg::OP_READ_WORD;
            end
        end
    end

    // Transaction attributes for the sequencer
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            curPosted_reg   <= 1'b0;
            curLockedRd_reg <= 1'b0;
            curLockedWr_reg <= 1'b0;
            curRead_reg     <= 1'b0;
            curMsg_reg      <= 1'b0;
            cacheable_reg   <= 1'b0;
        end else if (takeReq) begin
            curPosted_reg   <= lclWrite && !interagentMessage && !seqFlag && !lockedWr;
            curLockedRd_reg <= lockedRd && !interagentMessage;
            curLockedWr_reg <= lockedWr && !interagentMessage;
            curRead_reg     <= !lclWrite && !interagentMessage;
            curMsg_reg      <= interagentMessage;
            cacheable_reg   <= cacheHint && !lockedRd && !lockedWr;
        end else if (addrCycle && !recogHit) begin
            cacheable_reg   <= 1'b0;
        end
    end

    assign sendDone  = (state_reg == lsb_pkg::ST_SEND) && reqReady;
    assign wrSent    = sendDone && (reqPkt_reg.op == lsb_pkg::OP_WRITE_WORD ||
                                    reqPkt_reg.op == lsb_pkg::OP_LOCKED_WRITE);
    // In-order replies: our write is done when it is the last one in flight
    assign wrRplOk   = rplValid && rplPkt.forWrite && (outstanding_reg == lsb_pkg::OUTSTANDING_ONE);
    assign rplMine   = rplValid && !rplPkt.forWrite;
    // Locked reads return only after the closing beat
    assign rplFinish = rplMine && (!curLockedRd_reg || rplPkt.last);
    assign timeout   = (state_reg == lsb_pkg::ST_WAIT) && (timer_reg == lsb_pkg::RPL_TIMEOUT_CYC);
    assign waitDone  = timeout || (curRead_reg || curMsg_reg ? rplFinish : wrRplOk);
    assign wrFailed  = rplValid && rplPkt.forWrite &&
                       (rplPkt.kind == lsb_pkg::RPL_NACK || rplPkt.kind == lsb_pkg::RPL_BAD);

    // Sequencer
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            lsb_pkg::ST_IDLE:  if (takeReq) state_next = lsb_pkg::ST_RECOG;
            lsb_pkg::ST_RECOG: state_next = curLockedWr_reg ? lsb_pkg::ST_DRAIN : lsb_pkg::ST_SEND;
            lsb_pkg::ST_DRAIN: if (outstanding_reg == lsb_pkg::COUNT_ZERO) state_next = lsb_pkg::ST_SEND;
            lsb_pkg::ST_SEND:  if (reqReady) state_next = curPosted_reg ? lsb_pkg::ST_IDLE : lsb_pkg::ST_WAIT;
            lsb_pkg::ST_WAIT:  if (waitDone) state_next = lsb_pkg::ST_DONE;
            lsb_pkg::ST_DONE:  state_next = lsb_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= lsb_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Reply timer; a stuck far end cannot hold the reply wait state forever
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            timer_reg <= lsb_pkg::TIMER_ZERO;
        end else if (state_reg != lsb_pkg::ST_WAIT) begin
            timer_reg <= lsb_pkg::TIMER_ZERO;
        end else if (!timeout) begin
            timer_reg <= timer_reg + 12'h001;
        end
    end

    // Writes in flight; drained before a locked write
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            outstanding_reg <= lsb_pkg::COUNT_ZERO;
        end else if (wrSent && !(rplValid && rplPkt.forWrite)) begin
            if (outstanding_reg != lsb_pkg::OUTSTANDING_MAX) begin
                outstanding_reg <= outstanding_reg + 4'h1;
            end
        end else if (!wrSent && rplValid && rplPkt.forWrite &&
                     outstanding_reg != lsb_pkg::COUNT_ZERO) begin
            outstanding_reg <= outstanding_reg - 4'h1;
        end
    end

    // Refused write remembered; the failure appears on a later read
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            failValid_reg <= 1'b0;
            failAddr_reg  <= lsb_pkg::WORD_ZERO;
        end else if (wrFailed) begin
            failValid_reg <= 1'b1;
            failAddr_reg  <= rplPkt.addr;
        end else if (timeout && !curRead_reg && !curMsg_reg) begin
            failValid_reg <= 1'b1;
            failAddr_reg  <= reqPkt_reg.addr;
        end else if (wrSent && reqPkt_reg.addr[31:2] == failAddr_reg[31:2]) begin
            failValid_reg <= 1'b0;
        end
    end

    // Bad-access decision from the first reply beat, timeout or a failed location
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            badFlag_reg   <= 1'b0;
            firstBeat_reg <= 1'b1;
        end else if (state_reg == lsb_pkg::ST_RECOG) begin
            badFlag_reg   <= curRead_reg && failValid_reg &&
                             reqPkt_reg.addr[31:2] == failAddr_reg[31:2];
            firstBeat_reg <= 1'b1;
        end else if (state_reg == lsb_pkg::ST_WAIT) begin
            if (timeout && (curRead_reg || curMsg_reg)) begin
                badFlag_reg <= 1'b1;
            end else if (rplMine && firstBeat_reg) begin
                firstBeat_reg <= 1'b0;
                if (rplPkt.kind == lsb_pkg::RPL_BAD) begin
                    badFlag_reg <= 1'b1;
                end else if (curMsg_reg && rplPkt.kind == lsb_pkg::RPL_NACK) begin
                    badFlag_reg <= 1'b1;
                end
            end
        end
    end

    // Read data captured from the first data beat
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lclRdata_reg <= lsb_pkg::WORD_ZERO;
        end else if (state_reg == lsb_pkg::ST_WAIT && rplMine && firstBeat_reg &&
                     rplPkt.kind == lsb_pkg::RPL_DATA) begin
            lclRdata_reg <= rplPkt.data;
        end
    end

    // Posted writes finish when taken, after the single recognition wait
    assign readyPulse = (state_reg == lsb_pkg::ST_DONE) || (sendDone && curPosted_reg);
    assign readyN     = !readyPulse;
    // Bad access shares the last data cycle of the transaction
    assign badAccessN = !(state_reg == lsb_pkg::ST_DONE && badFlag_reg);
    assign lclRdata   = lclRdata_reg;
    assign cacheable  = cacheable_reg;
    assign reqValid   = (state_reg == lsb_pkg::ST_SEND);
    assign reqPkt     = reqPkt_reg;

    // Serving half: lanes and strobes for packets from the system bus
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            srvValid_reg   <= 1'b0;
            srvLanes_reg   <= lsb_pkg::LANES_NONE;
            srvStrobes_reg <= lsb_pkg::LANES_NONE;
        end else begin
            srvValid_reg <= inReqValid && inReqReady && inReqPkt.op != lsb_pkg::OP_INTERAGENT;
            if (inReqValid && inReqReady) begin
                srvLanes_reg   <= lanesFromOp(inReqPkt.op, inReqPkt.addr[1:0]);
                srvStrobes_reg <= inReqPkt.marks;
            end
        end
    end

    // Incoming messages are answered; the local side waits until the answer leaves
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            srvPending_reg <= 1'b0;
            srvRplPkt_reg  <= '0;
        end else if (inReqValid && inReqReady && inReqPkt.op == lsb_pkg::OP_INTERAGENT) begin
            srvPending_reg         <= 1'b1;
            srvRplPkt_reg.addr     <= inReqPkt.addr;
            srvRplPkt_reg.data     <= lsb_pkg::WORD_ZERO;
            srvRplPkt_reg.forWrite <= 1'b0;
            srvRplPkt_reg.last     <= 1'b1;
            srvRplPkt_reg.kind     <= (!msgBufFull && msgPrioOk && (!msgIsReg || msgRegOk)) ?
                                      lsb_pkg::RPL_WACK : lsb_pkg::RPL_NACK;
        end else if (srvPending_reg && srvRplReady) begin
            srvPending_reg <= 1'b0;
        end
    end

    assign inReqReady  = !srvPending_reg;
    assign srvValid    = srvValid_reg;
    assign srvLanes    = srvLanes_reg;
    assign srvStrobes  = srvStrobes_reg;
    assign srvWaitN    = !srvPending_reg;
    assign srvRplValid = srvPending_reg;
    assign srvRplPkt   = srvRplPkt_reg;

    // Checks
    a_recog_wait: assert property (@(posedge clk_sys) disable iff (!rst_n)
        takeReq |=> readyN) else $error("ready came without the recognition wait");
    a_posted_ready: assert property (@(posedge clk_sys) disable iff (!rst_n)
        takeReq && lclWrite && !interagentMessage && !seqFlag && !lockedWr && reqReady
        |=> ##1 !readyN) else $error("posted write not ready after one wait");
    a_byte_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
        takeReq && !lclWrite && !interagentMessage && !lockedRd && oneLane
        |=> reqPkt.op == lsb_pkg::OP_READ_BYTE &&
            reqPkt.addr[1:0] == lowBitsFromLanes($past(byteLaneEnable)))
        else $error("byte read packet malformed");
    a_word_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
        reqValid && reqPkt.op != lsb_pkg::OP_READ_BYTE && reqPkt.op != lsb_pkg::OP_READ_DBYTE
        |-> reqPkt.addr[1:0] == lsb_pkg::LOW_ADDR_ZERO) else $error("low bits not zero");
    a_locked_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
        takeReq && lockedRd && !interagentMessage
        |=> reqPkt.op == lsb_pkg::OP_LOCKED_READ && !cacheable)
        else $error("locked read not formed");
    a_drain_first: assert property (@(posedge clk_sys) disable iff (!rst_n)
        reqValid && reqPkt.op == lsb_pkg::OP_LOCKED_WRITE |-> outstanding_reg == lsb_pkg::COUNT_ZERO)
        else $error("locked write sent with writes in flight");
    a_msg_waits: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_reg == lsb_pkg::ST_WAIT && curMsg_reg && !rplMine && !timeout |=> readyN)
        else $error("message finished without reply");
    a_bad_timeout: assert property (@(posedge clk_sys) disable iff (!rst_n)
        timeout && curRead_reg |=> !badAccessN && !readyN) else $error("timeout not flagged");
    a_nack_bad: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_reg == lsb_pkg::ST_WAIT && curMsg_reg && rplMine && rplPkt.kind == lsb_pkg::RPL_NACK
        |=> !badAccessN && !readyN) else $error("nack not relayed");
    a_srv_lanes: assert property (@(posedge clk_sys) disable iff (!rst_n)
        inReqValid && inReqReady && inReqPkt.op == lsb_pkg::OP_READ_WORD
        |=> srvValid && srvLanes == lsb_pkg::LANES_ALL) else $error("word lanes wrong");
    a_srv_wait: assert property (@(posedge clk_sys) disable iff (!rst_n)
        srvRplValid && !srvRplReady |=> !srvWaitN && srvRplValid)
        else $error("incoming message released early");
    c_locked_read: cover property (@(posedge clk_sys) disable iff (!rst_n)
        state_reg == lsb_pkg::ST_DONE && curLockedRd_reg);
    c_locked_write: cover property (@(posedge clk_sys) disable iff (!rst_n)
        state_reg == lsb_pkg::ST_DRAIN ##1 state_reg == lsb_pkg::ST_SEND);
    c_msg_nack: cover property (@(posedge clk_sys) disable iff (!rst_n)
        srvRplValid && srvRplReady && srvRplPkt.kind == lsb_pkg::RPL_NACK);
    c_bad_read: cover property (@(posedge clk_sys) disable iff (!rst_n)
        !badAccessN && curRead_reg);

endmodule : lsb_bridge

// ---- sim/lsb_sys_model.sv ----
// Purpose: System bus far side, one request at a time, reply after a few cycles
// Assumes: Requests taken on reqValid while idle; one beat per reply
// Notes:   Reply data lines show a changing pattern outside reply beats
`timescale 1ns/10ps
module lsb_sys_model (
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic              reqValid,
    input  wire lsb_pkg::lsb_req_s reqPkt,
    input  wire logic [1:0]        rKind,
    output logic                   reqReady,
    output logic                   rplValid,
    output lsb_pkg::lsb_rpl_s      rplPkt
);
    logic              busy_reg;
    logic [3:0]        wait_reg;
    lsb_pkg::lsb_req_s held_reg;
    logic              isWr;
    // Accept, then count down a fixed reply delay; stalls new requests meanwhile
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            busy_reg <= 1'b0;
            wait_reg <= 4'h0;
            held_reg <= '0;
        end else if (reqValid && !busy_reg) begin
            busy_reg <= 1'b1;
            wait_reg <= 4'h3;
            held_reg <= reqPkt;
        end else if (busy_reg && wait_reg == 4'h0) begin
            busy_reg <= 1'b0;
        end else if (busy_reg) begin
            wait_reg <= wait_reg - 4'h1;
        end
    end
    // Writes always acknowledged; other replies take the kind the bench asks for
    assign isWr     = held_reg.op == lsb_pkg::OP_WRITE_WORD || held_reg.op == lsb_pkg::OP_LOCKED_WRITE;
    assign reqReady = !busy_reg;
    assign rplValid = busy_reg && wait_reg == 4'h0;
    assign rplPkt   = '{isWr ? lsb_pkg::RPL_WACK : rKind, isWr, rplValid, held_reg.addr,
                        rplValid ? ~held_reg.addr : {8{wait_reg}}};
endmodule : lsb_sys_model

// ---- sim/tb.sv ----
// Purpose: Self-checking bench for the local to system bus converter
// Assumes: Inputs driven at the falling edge; reply model answers every request
// Notes:   Timeout path not exercised, it costs a thousand idle cycles
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin n_fail++; \
    $display("[FAIL] %s exp %h got %h", nm, ex, gt); end end
module tb;
    logic clk_sys = 1'b0, rst_n = 1'b0, addrCycle = 1'b0, lclWrite = 1'b0, busLockN = 1'b1;
    logic recogHit = 1'b1, msg = 1'b0, inReqValid = 1'b0, msgBufFull = 1'b0, gotBad;
    logic cHint = 1'b1, seqF = 1'b0, srvRdy = 1'b1;
    logic [3:0] lanes = 4'hf;
    logic [1:0] rKind = lsb_pkg::RPL_DATA;
    logic [2:0] lastOp;
    logic [1:0] lastLow;
    logic readyN, badAccessN, cacheable, reqValid, reqReady, rplValid, inReqReady, srvValid;
    logic srvWaitN, srvRplValid;
    logic [31:0] lclRdata;
    logic [3:0] srvLanes;
    lsb_pkg::lsb_req_s reqPkt, inReqPkt = '0;
    lsb_pkg::lsb_rpl_s rplPkt, srvRplPkt;
    int n_fail = 0, n_checks = 0, cyc = 0;
    always #2 clk_sys = ~clk_sys;
    lsb_bridge dut (.clk_sys(clk_sys), .rst_n(rst_n), .addrCycle(addrCycle), .lclAddr(32'h0000_1230),
        .lclWrite(lclWrite), .byteLaneEnable(lanes), .busLockN(busLockN), .cacheHint(cHint),
        .recogHit(recogHit), .seqFlag(seqF), .interagentMessage(msg), .lclWdata(32'h1234_5678),
        .readyN(readyN), .badAccessN(badAccessN), .lclRdata(lclRdata), .cacheable(cacheable),
        .reqValid(reqValid), .reqReady(reqReady), .reqPkt(reqPkt), .rplValid(rplValid),
        .rplPkt(rplPkt), .inReqValid(inReqValid), .inReqReady(inReqReady), .inReqPkt(inReqPkt),
        .msgBufFull(msgBufFull), .msgPrioOk(1'b1), .msgIsReg(1'b0), .msgRegOk(1'b1),
        .srvValid(srvValid), .srvLanes(srvLanes), .srvStrobes(), .srvWaitN(srvWaitN),
        .srvRplValid(srvRplValid), .srvRplReady(srvRdy), .srvRplPkt(srvRplPkt));
    lsb_sys_model sys (.clk_sys(clk_sys), .rst_n(rst_n), .reqValid(reqValid), .reqPkt(reqPkt),
        .rKind(rKind), .reqReady(reqReady), .rplValid(rplValid), .rplPkt(rplPkt));
    // Record each packet the system bus takes; hang guard
    always @(posedge clk_sys) begin
        if (reqValid && reqReady) begin
            lastOp  <= reqPkt.op;
            lastLow <= reqPkt.addr[1:0];
        end
        cyc++;
        if (cyc == 4000) begin
            n_fail++;
            end_of_test();
        end
    end
    // One local transaction; waits boundedly for ready and keeps the bad-access level
    task automatic acc(input logic wr, input logic [3:0] ln, input logic lk, input logic m);
        int i;
        @(negedge clk_sys);
        addrCycle = 1'b1; lclWrite = wr; lanes = ln; busLockN = lk; msg = m;
        @(negedge clk_sys);
        addrCycle = 1'b0;
        for (i = 0; i < 200 && readyN !== 1'b0; i++) @(negedge clk_sys);
        gotBad = badAccessN;
        `CHK("ready", 1'b0, readyN)
        // Let the packet monitor record a write taken in the ready cycle
        @(negedge clk_sys);
    endtask : acc
    // Read packet kind and low address bits for each single lane, both halfword pairs and all four lanes
    task automatic t_reads();
        logic [3:0] ln [7] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf};
        logic [2:0] op [7] = '{0, 0, 0, 0, 1, 1, 2};
        logic [1:0] lo [7] = '{0, 1, 2, 3, 0, 2, 0};
        for (int k = 0; k < 7; k++) begin
            acc(1'b0, ln[k], 1'b1, 1'b0);
            `CHK("op", op[k], lastOp)
            `CHK("low", lo[k], lastLow)
            `CHK("rdata", 32'hffff_edcf ^ {30'h0, lo[k]}, lclRdata)
        end
        $display("t_reads done");
    endtask : t_reads
    // Lock opens with a read, inner accesses plain, release on a write
    task automatic t_lock();
        acc(1'b0, 4'hf, 1'b0, 1'b0);
        `CHK("lockRd", lsb_pkg::OP_LOCKED_READ, lastOp)
        `CHK("cacheLk", 1'b0, cacheable)
        seqF = 1'b1;
        acc(1'b1, 4'h3, 1'b0, 1'b0);
        seqF = 1'b0;
        `CHK("innerWr", lsb_pkg::OP_WRITE_WORD, lastOp)
        acc(1'b0, 4'hf, 1'b0, 1'b0);
        `CHK("innerRd", lsb_pkg::OP_READ_WORD, lastOp)
        `CHK("cacheOk", 1'b1, cacheable)
        cHint = 1'b0;
        acc(1'b0, 4'hf, 1'b0, 1'b0);
        cHint = 1'b1;
        `CHK("cacheNo", 1'b0, cacheable)
        acc(1'b1, 4'hf, 1'b1, 1'b0);
        `CHK("lockWr", lsb_pkg::OP_LOCKED_WRITE, lastOp)
        $display("t_lock done");
    endtask : t_lock
    // Message refused by the far bridge shows bad access at ready
    task automatic t_msg();
        rKind = lsb_pkg::RPL_NACK;
        acc(1'b1, 4'hf, 1'b1, 1'b1);
        `CHK("nackBad", 1'b0, gotBad)
        rKind = lsb_pkg::RPL_WACK;
        acc(1'b1, 4'hf, 1'b1, 1'b1);
        `CHK("ackBad", 1'b1, gotBad)
        $display("t_msg done");
    endtask : t_msg
    // Incoming request seen one cycle after it is taken
    task automatic srv(input logic [2:0] op, input logic [1:0] lo, input logic full,
                       input logic [3:0] exp);
        @(negedge clk_sys);
        inReqValid = 1'b1; inReqPkt = '{op, {30'h0, lo}, 32'h0, 4'hf}; msgBufFull = full;
        srvRdy = 1'b0;
        @(negedge clk_sys);
        inReqValid = 1'b0;
        if (op == lsb_pkg::OP_INTERAGENT) begin
            `CHK("srvKind", exp[1:0], srvRplPkt.kind)
            @(negedge clk_sys);
            `CHK("srvWait", 1'b0, srvWaitN)
        end else begin
            `CHK("srvLanes", exp, srvLanes)
            `CHK("srvValid", 1'b1, srvValid)
        end
        srvRdy = 1'b1;
        repeat (3) @(negedge clk_sys);
    endtask : srv
    initial begin
        repeat (4) @(negedge clk_sys);
        rst_n = 1'b1;
        t_reads();
        t_lock();
        t_msg();
        srv(3'h0, 2'h2, 1'b0, 4'h4);
        srv(3'h1, 2'h2, 1'b0, 4'hc);
        srv(3'h1, 2'h0, 1'b0, 4'h3);
        srv(3'h2, 2'h0, 1'b0, 4'hf);
        srv(3'h6, 2'h0, 1'b1, 4'h2);
        srv(3'h6, 2'h0, 1'b0, 4'h1);
        $display("t_serve done");
        end_of_test();
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_of_test
endmodule : tb
